// file: hw/iec_regs.svh
// register offsets, field positions and reset values of the idle gating block
// assumes byte addresses on a wishbone bus with 32-bit words
`ifndef IEC_REGS_SVH
`define IEC_REGS_SVH

// register byte offsets
`define IEC_OFS_CTRL   8'h00
`define IEC_OFS_STAT   8'h04
`define IEC_OFS_MMASK  8'h08
`define IEC_OFS_PMASK  8'h0C
`define IEC_OFS_CLKGEN 8'h10
`define IEC_OFS_GATED  8'h14

// domain bits of the control and status words
`define IEC_D_CPU   0
`define IEC_D_MP    1
`define IEC_D_IC    2
`define IEC_D_PERI  3
`define IEC_D_CLK   4
`define IEC_D_EXTERNAL_MEMORY_INTERFACE  5
`define IEC_DOM_W   6

// master mask bits
`define IEC_MM_DMA  0
`define IEC_MM_HPI  1
`define IEC_MM_W    2

// clock generator control bits
`define IEC_CG_PLLPD 0
`define IEC_CG_OSCPD 1
`define IEC_CG_W     2

// gated units; peripheral mask bit k steers unit IEC_U_PER0 + k
`define IEC_U_CPU    0
`define IEC_U_GRP    1
`define IEC_U_DMA    2
`define IEC_U_HPI    3
`define IEC_U_IC     4
`define IEC_U_PER0   5
`define IEC_U_BSP0   12
`define IEC_U_I2C    15
`define IEC_U_UART   16
`define IEC_U_EXTERNAL_MEMORY_INTERFACE   17
`define IEC_NUNIT    18
`define IEC_PM_W     13
`define IEC_NBSP     3

// reset values
`define IEC_RST_CTRL   6'h00
`define IEC_RST_MMASK  2'h0
`define IEC_RST_PMASK  13'h0000
`define IEC_RST_CLKGEN 2'h0

`endif

// file: hw/iec_pkg.sv
// types shared by the idle gating block
// assumes iec_regs.svh for the numeric layout
package iec_pkg;

   // wishbone classic request as seen by the slave
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } iec_wb_req_s;

   // per-unit gating state, gray along run -> drain -> idle
   typedef enum logic [1:0] {
      IEC_RUN   = 2'h0,
      IEC_DRAIN = 2'h1,
      IEC_IDLE  = 2'h3
   } iec_gate_e;

endpackage : iec_pkg

// file: hw/iec_gate.sv
// one gating cell: takes a unit into idle once its request stands and the
// unit reports no activity; assumes busy is synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none

module iec_gate (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // control
   input  wire logic req_i,
   input  wire logic busy_i,
   input  wire logic wake_i,
   // gate, high while the unit clock is stopped
   output logic      idle_o
);
   import iec_pkg::*;

   iec_gate_e st_q;
   iec_gate_e st_d;

   // a waking unit must raise busy at once or it re-enters idle next cycle
   always_comb begin
      st_d = st_q;
      case (st_q)
         IEC_RUN: begin
            if (req_i && !busy_i) st_d = IEC_IDLE;
            else if (req_i)       st_d = IEC_DRAIN;
         end
         IEC_DRAIN: begin
            if (!req_i)       st_d = IEC_RUN;
            else if (!busy_i) st_d = IEC_IDLE;
         end
         IEC_IDLE: begin
            if (!req_i || wake_i) st_d = IEC_RUN;
         end
         default: st_d = IEC_RUN;
      endcase
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) st_q <= IEC_RUN;
      else       st_q <= st_d;
   end

   assign idle_o = st_q[1]; // only the idle code has bit 1 set

endmodule : iec_gate

`default_nettype wire

// file: hw/iec_top.sv
// idle entry and clock gating control with its wishbone register file
// assumes all activity inputs and the idle pulse are synchronous to clk_i
//
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "iec_regs.svh"

module iec_top (
   // clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // register bus
   input  wire iec_pkg::iec_wb_req_s     wb_i,
   output logic [31:0]                   wb_dat_o,
   output logic                          wb_ack_o,
   // cpu side
   input  wire logic                     idle_exec_i,
   input  wire logic                     cpu_wake_i,
   input  wire logic                     pipe_stopped_i,
   // activity of the gated units
   input  wire logic                     dma_busy_i,
   input  wire logic                     instruction_cache_busy_i,
   input  wire logic [`IEC_NBSP-1:0]     bsp_busy_i,
   input  wire logic [`IEC_NBSP-1:0]     bsp_xfer_i,
   input  wire logic [`IEC_NBSP-1:0]     bsp_ext_clk_i,
   input  wire logic [`IEC_NBSP-1:0]     transmitter_reset_bit_i,
   input  wire logic [`IEC_NBSP-1:0]     receiver_reset_bit_i,
   input  wire logic                     i2c_busy_i,
   input  wire logic                     uart_busy_i,
   // gates and power-down controls
   output logic [`IEC_NUNIT-1:0]         gate_o,
   output logic                          refresh_inhibit_o,
   output logic                          pll_pd_o,
   output logic                          osc_pd_o
);
   import iec_pkg::*;

   // registers
   logic [`IEC_DOM_W-1:0] idle_control_word_q;
   logic [`IEC_DOM_W-1:0] idle_status_word_q;
   logic [`IEC_DOM_W-1:0] stat_d;
   logic [`IEC_MM_W-1:0]  master_idle_mask_q;
   logic [`IEC_PM_W-1:0]  peripheral_idle_mask_q;
   logic [`IEC_CG_W-1:0]  clkgen_q;
   logic                  ack_q;
   logic [31:0]           dat_q;
   logic                  pll_pd_q;
   logic                  osc_pd_q;
   logic                  refresh_inh_q;

   // bus decode
   logic        acc;
   logic        wr;
   logic        hit_ctrl;
   logic        hit_stat;
   logic        hit_mmask;
   logic        hit_pmask;
   logic        hit_clkgen;
   logic        hit_gated;
   logic [31:0] rd_data;
   logic [31:0] mrg_ctrl;
   logic [31:0] mrg_mmask;
   logic [31:0] mrg_pmask;
   logic [31:0] mrg_clkgen;

   // unit control vectors
   logic [`IEC_NUNIT-1:0] req;
   logic [`IEC_NUNIT-1:0] busy;
   logic [`IEC_NUNIT-1:0] wake;
   logic [`IEC_NUNIT-1:0] gate;
   logic [`IEC_NBSP-1:0]  bsp_aw;
   logic                  any_aw;
   logic                  peri_on;

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) r[8*b +: 8] = new_v[8*b +: 8];
      end
      return r;
   endfunction : merge

   // classic single cycle: one wait state, ack for one cycle
   assign acc        = wb_i.cyc & wb_i.stb & ~ack_q;
   assign wr         = acc & wb_i.we;
   assign hit_ctrl   = (wb_i.adr == `IEC_OFS_CTRL);
   assign hit_stat   = (wb_i.adr == `IEC_OFS_STAT);
   assign hit_mmask  = (wb_i.adr == `IEC_OFS_MMASK);
   assign hit_pmask  = (wb_i.adr == `IEC_OFS_PMASK);
   assign hit_clkgen = (wb_i.adr == `IEC_OFS_CLKGEN);
   assign hit_gated  = (wb_i.adr == `IEC_OFS_GATED);

   // write data merged by byte lane; the register takes its low bits only
   assign mrg_ctrl   = merge({26'h0, idle_control_word_q}, wb_i.dat,
                             wb_i.sel);
   assign mrg_mmask  = merge({30'h0, master_idle_mask_q}, wb_i.dat,
                             wb_i.sel);
   assign mrg_pmask  = merge({19'h0, peripheral_idle_mask_q}, wb_i.dat,
                             wb_i.sel);
   assign mrg_clkgen = merge({30'h0, clkgen_q}, wb_i.dat, wb_i.sel);

   // read select; unmapped offsets answer with zero
   assign rd_data =
      hit_ctrl   ? {26'h0, idle_control_word_q} :
      hit_stat   ? {26'h0, idle_status_word_q} :
      hit_mmask  ? {30'h0, master_idle_mask_q} :
      hit_pmask  ? {19'h0, peripheral_idle_mask_q} :
      hit_clkgen ? {30'h0, clkgen_q} :
      hit_gated  ? {14'h0, gate} : 32'h0;

   // bus answer registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end else begin
         ack_q <= acc;
         dat_q <= acc ? rd_data : dat_q;
      end
   end

   // software registers; the status word is read-only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_control_word_q    <= `IEC_RST_CTRL;
         master_idle_mask_q     <= `IEC_RST_MMASK;
         peripheral_idle_mask_q <= `IEC_RST_PMASK;
         clkgen_q               <= `IEC_RST_CLKGEN;
      end else if (wr) begin
         if (hit_ctrl)   idle_control_word_q    <= mrg_ctrl[`IEC_DOM_W-1:0];
         if (hit_mmask)  master_idle_mask_q     <= mrg_mmask[`IEC_MM_W-1:0];
         if (hit_pmask)  peripheral_idle_mask_q <= mrg_pmask[`IEC_PM_W-1:0];
         if (hit_clkgen) clkgen_q               <= mrg_clkgen[`IEC_CG_W-1:0];
      end
   end

   // status word: idle instruction wins over a cpu wake in the same cycle
   always_comb begin
      stat_d = idle_status_word_q;
      if (idle_exec_i) begin
         stat_d = idle_control_word_q;
      end else if (cpu_wake_i && idle_status_word_q[`IEC_D_CPU]) begin
         stat_d[`IEC_D_CPU]  = 1'b0;
         stat_d[`IEC_D_CLK]  = 1'b0;
         stat_d[`IEC_D_EXTERNAL_MEMORY_INTERFACE] = 1'b0;
      end
   end

   // status register
   always_ff @(posedge clk_i) begin
      if (rst_i) idle_status_word_q <= `IEC_RST_CTRL;
      else       idle_status_word_q <= stat_d;
   end

   // cpu domain: the cpu waits for its pipeline, its satellites for it
   assign req[`IEC_U_CPU]  = idle_status_word_q[`IEC_D_CPU];
   assign busy[`IEC_U_CPU] = ~pipe_stopped_i;
   assign req[`IEC_U_GRP]  = idle_status_word_q[`IEC_D_CPU];
   assign busy[`IEC_U_GRP] = ~gate[`IEC_U_CPU];

   // master port domain: hpi is cut even mid-transfer, software guards it
   assign req[`IEC_U_DMA]  = idle_status_word_q[`IEC_D_MP] &
                             master_idle_mask_q[`IEC_MM_DMA];
   assign busy[`IEC_U_DMA] = dma_busy_i;
   assign req[`IEC_U_HPI]  = idle_status_word_q[`IEC_D_MP] &
                             master_idle_mask_q[`IEC_MM_HPI];
   assign busy[`IEC_U_HPI] = 1'b0;

   // instruction cache waits for a fill or a fetch in flight
   assign req[`IEC_U_IC]  = idle_status_word_q[`IEC_D_IC];
   assign busy[`IEC_U_IC] = instruction_cache_busy_i;

   // peripheral domain requests; the memory interface has two routes
   assign peri_on = idle_status_word_q[`IEC_D_PERI];
   genvar k;
   generate
      for (k = 0; k < `IEC_PM_W; k++) begin : g_preq
         if (`IEC_U_PER0 + k == `IEC_U_EXTERNAL_MEMORY_INTERFACE) begin : g_external_memory_interface
            assign req[`IEC_U_PER0 + k] =
               (peri_on & peripheral_idle_mask_q[k]) |
               idle_status_word_q[`IEC_D_EXTERNAL_MEMORY_INTERFACE];
         end else begin : g_plain
            assign req[`IEC_U_PER0 + k] =
               peri_on & peripheral_idle_mask_q[k];
         end
      end
   endgenerate

   // timers, watchdog, tick timer, gpio blocks and divider never stall
   assign busy[`IEC_U_BSP0-1:`IEC_U_PER0] = '0;
   assign busy[`IEC_U_I2C]  = i2c_busy_i;
   assign busy[`IEC_U_UART] = uart_busy_i;
   assign busy[`IEC_U_EXTERNAL_MEMORY_INTERFACE] = dma_busy_i;

   // serial ports: external clock drains and may auto-wake the dma with
   // it; internal clock blocks idle while either section is out of reset
   generate
      for (k = 0; k < `IEC_NBSP; k++) begin : g_bsp
         assign busy[`IEC_U_BSP0 + k] = bsp_ext_clk_i[k] ?
            bsp_busy_i[k] :
            (transmitter_reset_bit_i[k] | receiver_reset_bit_i[k]);
         assign bsp_aw[k] = bsp_ext_clk_i[k] & bsp_xfer_i[k] &
                            gate[`IEC_U_BSP0 + k] & gate[`IEC_U_DMA];
         assign wake[`IEC_U_BSP0 + k] = bsp_aw[k];
      end
   endgenerate

   // wake sources other than the serial port pairing stay low
   assign any_aw = |bsp_aw;
   assign wake[`IEC_U_BSP0-1:`IEC_U_HPI] = '0;
   assign wake[`IEC_U_DMA] = any_aw;
   assign wake[`IEC_U_GRP:`IEC_U_CPU] = '0;
   assign wake[`IEC_NUNIT-1:`IEC_U_BSP0+`IEC_NBSP] = '0;

   // one gating cell per unit
   generate
      for (k = 0; k < `IEC_NUNIT; k++) begin : g_cell
         iec_gate u_gate (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .req_i  (req[k]),
            .busy_i (busy[k]),
            .wake_i (wake[k]),
            .idle_o (gate[k])
         );
      end
   endgenerate

   // clock generator powers down only behind a stopped cpu, so the
   // wake interrupt path is already quiet when the pll goes away
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pll_pd_q      <= 1'b0;
         osc_pd_q      <= 1'b0;
         refresh_inh_q <= 1'b0;
      end else begin
         pll_pd_q <= idle_status_word_q[`IEC_D_CLK] &
                     clkgen_q[`IEC_CG_PLLPD] & gate[`IEC_U_CPU];
         osc_pd_q <= idle_status_word_q[`IEC_D_CLK] &
                     clkgen_q[`IEC_CG_OSCPD] & gate[`IEC_U_CPU];
         refresh_inh_q <= gate[`IEC_U_EXTERNAL_MEMORY_INTERFACE] |
                          (req[`IEC_U_EXTERNAL_MEMORY_INTERFACE] & ~busy[`IEC_U_EXTERNAL_MEMORY_INTERFACE]);
      end
   end

   // outputs
   assign gate_o            = gate;
   assign wb_ack_o          = ack_q;
   assign wb_dat_o          = dat_q;
   assign pll_pd_o          = pll_pd_q;
   assign osc_pd_o          = osc_pd_q;
   assign refresh_inhibit_o = refresh_inh_q;

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_COPY: assert property (
      idle_exec_i |=> idle_status_word_q == $past(idle_control_word_q))
      else $error("status word missed the control word copy");

   AST_NO_REQ: assert property (
      ((gate & ~$past(gate)) & ~$past(req)) == '0)
      else $error("unit gated without its idle request");

   AST_CPU_PIPE: assert property (
      $rose(gate[`IEC_U_CPU]) |-> $past(pipe_stopped_i))
      else $error("cpu gated with its pipeline running");

   AST_GRP_AFTER: assert property (
      $rose(gate[`IEC_U_GRP]) |-> $past(gate[`IEC_U_CPU], 1))
      else $error("cpu satellites gated before the cpu");

   AST_DMA_DRAIN: assert property (
      $rose(gate[`IEC_U_DMA]) |-> !$past(dma_busy_i))
      else $error("dma gated during a transfer");

   AST_HPI_NOW: assert property (
      req[`IEC_U_HPI] && !gate[`IEC_U_HPI] ##1 req[`IEC_U_HPI]
         |-> gate[`IEC_U_HPI] || $past(gate[`IEC_U_HPI]) ||
             $rose(gate[`IEC_U_HPI]))
      else $error("host port did not idle at once");

   AST_TIMER_NOW: assert property (
      (req[`IEC_U_PER0] && !gate[`IEC_U_PER0]) [*2]
         |-> 1'b0)
      else $error("timer did not idle at once");

   AST_BSP_INT: assert property (
      $rose(gate[`IEC_U_BSP0]) && !$past(bsp_ext_clk_i[0]) |->
         !$past(transmitter_reset_bit_i[0]) &&
         !$past(receiver_reset_bit_i[0]))
      else $error("serial port idled with a section out of reset");

   AST_EXTERNAL_MEMORY_INTERFACE_DMA: assert property (
      $rose(gate[`IEC_U_EXTERNAL_MEMORY_INTERFACE]) |-> !$past(dma_busy_i))
      else $error("memory interface idled during a dma transfer");

   AST_PLL_PD: assert property (
      $rose(pll_pd_o) |-> $past(clkgen_q[`IEC_CG_PLLPD], 1) &&
                          $past(gate[`IEC_U_CPU], 1))
      else $error("pll powered down without software request");

   AST_REFRESH: assert property (
      gate[`IEC_U_EXTERNAL_MEMORY_INTERFACE] |-> refresh_inhibit_o)
      else $error("refresh allowed while memory interface idled");

   AST_AUTOWAKE: assert property (
      any_aw && req[`IEC_U_DMA] |=> !gate[`IEC_U_DMA])
      else $error("dma did not wake for serial port transfer");

   AST_CACHE_DRAIN: assert property (
      $rose(gate[`IEC_U_IC]) |-> !$past(instruction_cache_busy_i))
      else $error("cache idled with a fill or fetch pending");

   AST_SERIAL_DRAIN: assert property (
      $rose(gate[`IEC_U_BSP0]) && $past(bsp_ext_clk_i[0]) |->
         !$past(bsp_busy_i[0]))
      else $error("serial port idled during its activity");

   AST_I2C_DRAIN: assert property (
      $rose(gate[`IEC_U_I2C]) |-> !$past(i2c_busy_i))
      else $error("i2c idled during its activity");

   AST_PERI_MASK: assert property (
      $rose(gate[`IEC_U_PER0]) |-> $past(peripheral_idle_mask_q[0]) &&
                                   $past(idle_status_word_q[`IEC_D_PERI]))
      else $error("peripheral gated without mask bit and status");

endmodule : iec_top

`default_nettype wire

// file: sim/iec_units.sv
// behavioural model of the gated units and of the cpu pipeline
// assumes start pulses from the bench, synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none

module iec_units #(
   parameter int LAT = 4
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // cpu events
   input  wire logic       exec_i,
   input  wire logic       wake_i,
   // transfer starts and their length
   input  wire logic [6:0] start_i,
   input  wire logic [7:0] len_i,
   // activity and pipeline state
   output logic [6:0]      busy_o,
   output logic            stop_o
);
   logic [7:0] cnt_q [7];
   logic [3:0] pc_q;

   // a unit stays busy until its transfer has run out
   always_ff @(posedge clk_i) begin
      for (int k = 0; k < 7; k++) begin
         if (rst_i) begin
            cnt_q[k] <= 8'h00;
         end else if (start_i[k]) begin
            cnt_q[k] <= len_i;
         end else if (cnt_q[k] != 8'h00) begin
            cnt_q[k] <= cnt_q[k] - 8'h01;
         end
      end
   end

   // activity flags
   for (genvar k = 0; k < 7; k++) begin : g_busy
      assign busy_o[k] = (cnt_q[k] != 8'h00);
   end

   // pipeline drains LAT cycles after the idle instruction, so the gate
   // sees a late stop and cannot rely on the exec pulse alone
   always_ff @(posedge clk_i) begin
      if (rst_i || wake_i) begin
         pc_q   <= 4'h0;
         stop_o <= 1'h0;
      end else if (exec_i) begin
         // a new idle instruction means the pipeline is still running
         pc_q   <= 4'(LAT);
         stop_o <= 1'h0;
      end else if (pc_q != 4'h0) begin
         pc_q   <= pc_q - 4'h1;
         stop_o <= (pc_q == 4'h1);
      end
   end
endmodule : iec_units

`default_nettype wire

// file: sim/test_iec_top.sv
// self-checking bench of the idle gating block
// assumes iec_regs.svh on the include path and the unit model beside it
`timescale 1ns/1ps
`default_nettype none
`include "iec_regs.svh"

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
   error_cnt++; $display("ERROR %s exp %0h got %0h", nm, ex, got); end end

module test_iec_top;
   import iec_pkg::*;
   logic        clk;
   logic        rst;
   iec_wb_req_s wb;
   logic [31:0] wb_dat;
   logic        wb_ack;
   logic        exec;
   logic        wake;
   logic        pipe;
   logic [6:0]  busy;
   logic [6:0]  start;
   logic [7:0]  len;
   logic [2:0]  xfer;
   logic [2:0]  ext;
   logic [2:0]  txr;
   logic [2:0]  rxr;
   logic [17:0] gate;
   logic        rinh;
   logic        plpd;
   logic        ospd;
   int          error_cnt = 0;
   int          checks_done = 0;
   logic [31:0] ones [7] = '{32'h3F, 32'h0, 32'h3, 32'h1FFF, 32'h3, 32'h0,
                             32'h0};

   // design and unit model
   iec_top dut (.clk_i(clk), .rst_i(rst), .wb_i(wb), .wb_dat_o(wb_dat),
      .wb_ack_o(wb_ack), .idle_exec_i(exec), .cpu_wake_i(wake),
      .pipe_stopped_i(pipe), .dma_busy_i(busy[0]), .instruction_cache_busy_i(busy[1]),
      .bsp_busy_i(busy[4:2]), .bsp_xfer_i(xfer), .bsp_ext_clk_i(ext),
      .transmitter_reset_bit_i(txr), .receiver_reset_bit_i(rxr),
      .i2c_busy_i(busy[5]), .uart_busy_i(busy[6]), .gate_o(gate),
      .refresh_inhibit_o(rinh), .pll_pd_o(plpd), .osc_pd_o(ospd));
   iec_units units (.clk_i(clk), .rst_i(rst), .exec_i(exec), .wake_i(wake),
      .start_i(start), .len_i(len), .busy_o(busy), .stop_o(pipe));

   // clock source
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test

   // classic cycle: hold the request until ack is sampled high
   task automatic wb_xfer(input logic w, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      wb <= {1'h1, 1'h1, w, a, 4'hF, d};
      do @(posedge clk); while (wb_ack !== 1'h1);
      r = wb_dat;
      wb <= '0;
   endtask : wb_xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb_xfer(1'h1, a, d, r);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
      logic [31:0] r;
      wb_xfer(1'h0, a, 32'h0, r);
      `CHK(nm, e, r)
   endtask : rd

   // program masks and control word, then one idle instruction
   task automatic setup(input logic [31:0] c, m, p);
      wr(`IEC_OFS_MMASK, m);
      wr(`IEC_OFS_PMASK, p);
      wr(`IEC_OFS_CTRL, c);
      @(posedge clk);
      exec <= 1'h1;
      @(posedge clk);
      exec <= 1'h0;
   endtask : setup

   task automatic wait_g(input int i, input logic v, input int m);
      for (int n = 0; n < m && gate[i] !== v; n++) @(posedge clk);
      `CHK("gate", v, gate[i])
   endtask : wait_g

   task automatic go(input logic [6:0] s, input logic [7:0] l);
      @(posedge clk);
      start <= s;
      len   <= l;
      @(posedge clk);
      start <= 7'h00;
   endtask : go

   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end

   // main sequence
   initial begin
      rst = 1'h1;
      wb = '0;
      {exec, wake, start, len, xfer, txr, rxr} = '0;
      ext = 3'h1;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      // reset values, read-only places, unmapped word, width of each field
      for (int i = 0; i < 7; i++) begin
         rd(8'(i * 4), 32'h0, "reset value");
         wr(8'(i * 4), 32'hFFFFFFFF);
         rd(8'(i * 4), ones[i], "access");
         wr(8'(i * 4), 32'h0);
      end
      $display("test registers done");
      // immediate peripherals; cpu and master port stay clocked
      setup(32'h8, 32'h0, 32'h7F);
      for (int k = 5; k < 12; k++) wait_g(k, 1'h1, 4);
      rd(`IEC_OFS_STAT, 32'h8, "status");
      `CHK("unselected", 2'h0, {gate[0], gate[2]})
      wr(`IEC_OFS_PMASK, 32'h7E);
      wait_g(5, 1'h0, 4);
      setup(32'h0, 32'h0, 32'h0);
      $display("test peripherals done");
      // cpu waits for the pipeline, satellites wait for the cpu
      setup(32'h1, 32'h0, 32'h0);
      // let the exec edge pass so the cleared stop flag is seen
      @(posedge clk);
      for (int n = 0; n < 12 && pipe !== 1'h1; n++) begin
         @(posedge clk);
         `CHK("cpu early", 2'h0, gate[1:0])
      end
      wait_g(0, 1'h1, 4);
      wait_g(1, 1'h1, 4);
      @(posedge clk);
      wake <= 1'h1;
      @(posedge clk);
      wake <= 1'h0;
      wait_g(0, 1'h0, 4);
      $display("test cpu done");
      // dma busy; host port quiet when idled
      go(7'h01, 8'd30);
      setup(32'hA, 32'h3, 32'h1000);
      wait_g(3, 1'h1, 4);
      `CHK("dma early", 2'h0, {gate[2], gate[17]})
      `CHK("refresh on", 1'h0, rinh)
      wait_g(2, 1'h1, 40);
      wait_g(17, 1'h1, 40);
      `CHK("refresh", 1'h1, rinh)
      setup(32'h0, 32'h0, 32'h0);
      $display("test master port done");
      // instruction cache drains its fill first
      go(7'h02, 8'd30);
      setup(32'h4, 32'h0, 32'h0);
      `CHK("cache early", 1'h0, gate[4])
      wait_g(4, 1'h1, 40);
      setup(32'h0, 32'h0, 32'h0);
      $display("test cache done");
      // serial ports, i2c and uart: port 1 internal with its tx running
      txr <= 3'h2;
      go(7'h24, 8'd30);
      setup(32'hA, 32'h1, 32'h0F80);
      wait_g(14, 1'h1, 4);
      wait_g(16, 1'h1, 4);
      wait_g(2, 1'h1, 4);
      `CHK("busy ports", 2'h0, {gate[12], gate[15]})
      wait_g(12, 1'h1, 40);
      wait_g(15, 1'h1, 40);
      `CHK("port in use", 1'h0, gate[13])
      // new serial transfer wakes port 0 and the dma, then both re-idle
      @(posedge clk);
      xfer  <= 3'h1;
      start <= 7'h05;
      len   <= 8'd8;
      @(posedge clk);
      xfer  <= 3'h0;
      start <= 7'h00;
      wait_g(2, 1'h0, 3);
      `CHK("port woke", 1'h0, gate[12])
      wait_g(2, 1'h1, 20);
      wait_g(12, 1'h1, 20);
      setup(32'h0, 32'h0, 32'h0);
      $display("test serial done");
      // pll power-down chosen beforehand, oscillator left running
      wr(`IEC_OFS_CLKGEN, 32'h1);
      setup(32'h11, 32'h0, 32'h0);
      wait_g(0, 1'h1, 12);
      repeat (3) @(posedge clk);
      `CHK("power down", 2'h1, {ospd, plpd})
      @(posedge clk);
      wake <= 1'h1;
      @(posedge clk);
      wake <= 1'h0;
      repeat (3) @(posedge clk);
      `CHK("power up", 1'h0, plpd)
      // oscillator chosen alone this time, pll left running
      wr(`IEC_OFS_CLKGEN, 32'h2);
      setup(32'h11, 32'h0, 32'h0);
      wait_g(0, 1'h1, 12);
      repeat (3) @(posedge clk);
      `CHK("osc down", 2'h2, {ospd, plpd})
      $display("test clock done");
      end_of_test();
   end
endmodule : test_iec_top

`default_nettype wire
